/* hdl/flash_status_params.svh */
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// status register bit positions
`define SR_BUSY_BIT 3'd0
`define SR_LATCH_BIT 3'd1
`define SR_BP_LSB 3'd2
`define SR_BP_MSB 3'd5
`define SR_QUAD_BIT 3'd6
`define SR_LOCK_BIT 3'd7
`define SR_RESET_VAL 8'h00

// array geometry
`define SECTOR_SHIFT 5'd12
`define SECTOR_LAST 21'h000fff
`define SMALL_BLOCK_SHIFT 5'd15
`define LARGE_BLOCK_SHIFT 5'd16
`define ARRAY_TOP 21'h1fffff

// command codes
`define CMD_WRITE_STATUS 8'h01
`define CMD_READ_STATUS 8'h05
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_CHIP_ERASE 8'hc7
`define CMD_CHIP_ERASE_ALT 8'h60
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_SECTOR_ERASE 8'h20
`define CMD_SMALL_BLOCK_ERASE 8'h52
`define CMD_LARGE_BLOCK_ERASE 8'hd8

// busy time of a non-volatile write, in cycles (arbitrary plain default)
`define NV_BUSY_CYCLES 16'd100

`endif

/* hdl/flash_status_pkg.sv */
package flash_status_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01
    } op_state_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_STATUS = 3'b001,
        OP_PROGRAM = 3'b010,
        OP_ERASE = 3'b011,
        OP_CHIP = 3'b100
    } op_kind_e;
endpackage : flash_status_pkg

/* hdl/sector_address_map.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_params.svh"

// ****************************************************************
// address decomposition into sector and block numbers
// ****************************************************************
module sector_address_map (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [20:0] addr_i,
    output logic [8:0] sector_o,
    output logic [5:0] small_block_o,
    output logic [4:0] large_block_o,
    output logic [20:0] sector_base_o,
    output logic [20:0] sector_end_o
);
    // registered so that top outputs come straight from flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sector_o <= 9'h000;
            small_block_o <= 6'h00;
            large_block_o <= 5'h00;
            sector_base_o <= 21'h000000;
            sector_end_o <= 21'h000000;
        end else begin
            sector_o <= addr_i[20:12];
            small_block_o <= addr_i[20:15];
            large_block_o <= addr_i[20:16];
            sector_base_o <= {addr_i[20:12], 12'h000};
            sector_end_o <= {addr_i[20:12], 12'h000} | `SECTOR_LAST;
        end
    end
endmodule : sector_address_map
`default_nettype wire

/* hdl/flash_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_params.svh"

module flash_status_regs
    import flash_status_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic [20:0] cmd_addr_i,
    input wire logic write_protect_n_i,
    output logic [7:0] read_data_o,
    output logic read_valid_o,
    output logic cmd_ignored_o,
    output logic quad_enable_o,
    output logic busy_o,
    output logic [8:0] sector_o,
    output logic [5:0] small_block_o,
    output logic [4:0] large_block_o,
    output logic [20:0] sector_base_o,
    output logic [20:0] sector_end_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    op_state_e state_q;
    op_kind_e op_q;
    logic [15:0] busy_cnt_q;
    logic write_in_progress_flag_q;
    logic write_enable_latch_q;
    logic [3:0] block_protect_q;
    logic quad_enable_q;
    logic status_write_lock_q;
    logic [7:0] pending_q;
    logic [7:0] status_byte;
    logic is_status_wr, is_prog, is_erase, is_chip, start_ok;
    logic locked, op_done, is_modify, accept;

    // full status byte, msb first as packed
    assign status_byte = {status_write_lock_q, quad_enable_q,
                          block_protect_q, write_enable_latch_q,
                          write_in_progress_flag_q};

    // command decode
    assign is_status_wr = cmd_valid_i && (cmd_code_i == `CMD_WRITE_STATUS);
    assign is_prog = cmd_valid_i && (cmd_code_i == `CMD_PAGE_PROGRAM);
    assign is_erase = cmd_valid_i && ((cmd_code_i == `CMD_SECTOR_ERASE) ||
        (cmd_code_i == `CMD_SMALL_BLOCK_ERASE) ||
        (cmd_code_i == `CMD_LARGE_BLOCK_ERASE));
    assign is_chip = cmd_valid_i && ((cmd_code_i == `CMD_CHIP_ERASE) ||
        (cmd_code_i == `CMD_CHIP_ERASE_ALT));
    assign locked = status_write_lock_q && !write_protect_n_i;
    // a modifying op needs the latch and an idle device
    assign start_ok = (state_q == ST_IDLE) && write_enable_latch_q;
    assign op_done = (state_q == ST_BUSY) && (busy_cnt_q == 16'h0001);
    // one accept term feeds both the sequencer and the refusal pulse,
    // so the two can never disagree about a command
    assign is_modify = is_status_wr || is_prog || is_erase || is_chip;
    assign accept = start_ok && ((is_status_wr && !locked) || is_prog ||
        is_erase || (is_chip && block_protect_q == 4'h0));

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    // busy flag tracks the sequencer; no external write path exists
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            busy_cnt_q <= 16'h0000;
            write_in_progress_flag_q <= 1'b0;
            pending_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_BUSY;
                        busy_cnt_q <= `NV_BUSY_CYCLES;
                        write_in_progress_flag_q <= 1'b1;
                        pending_q <= cmd_data_i;
                        if (is_status_wr) begin
                            op_q <= OP_STATUS;
                        end else if (is_prog) begin
                            op_q <= OP_PROGRAM;
                        end else if (is_erase) begin
                            op_q <= OP_ERASE;
                        end else begin
                            op_q <= OP_CHIP;
                        end
                    end
                end
                ST_BUSY: begin
                    busy_cnt_q <= busy_cnt_q - 16'h0001;
                    if (op_done) begin
                        state_q <= ST_IDLE;
                        op_q <= OP_NONE;
                        write_in_progress_flag_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // non-volatile bits
    // ****************************************************************
    // committed only at the end of an accepted status write, so a lost
    // operation never leaves half-updated protection
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_protect_q <= 4'h0;
            quad_enable_q <= 1'b0;
            status_write_lock_q <= 1'b0;
        end else if (op_done && op_q == OP_STATUS) begin
            block_protect_q <= pending_q[5:2];
            quad_enable_q <= pending_q[6];
            status_write_lock_q <= pending_q[7];
        end
    end

    // ****************************************************************
    // write enable latch
    // ****************************************************************
    // completion clear takes priority over an enable in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_enable_latch_q <= 1'b0;
        end else if (op_done) begin
            write_enable_latch_q <= 1'b0;
        end else if (cmd_valid_i && cmd_code_i == `CMD_WRITE_DISABLE) begin
            write_enable_latch_q <= 1'b0;
        end else if (cmd_valid_i && cmd_code_i == `CMD_WRITE_ENABLE) begin
            write_enable_latch_q <= 1'b1;
        end
    end

    // ****************************************************************
    // read port and flags
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_data_o <= 8'h00;
            read_valid_o <= 1'b0;
            cmd_ignored_o <= 1'b0;
            quad_enable_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            read_valid_o <= cmd_valid_i &&
                (cmd_code_i == `CMD_READ_STATUS);
            if (cmd_valid_i && cmd_code_i == `CMD_READ_STATUS) begin
                read_data_o <= status_byte;
            end
            // pulse when a modifying command is dropped
            cmd_ignored_o <= is_modify && !accept;
            quad_enable_o <= quad_enable_q;
            busy_o <= write_in_progress_flag_q;
        end
    end

    // ****************************************************************
    // address map
    // ****************************************************************
    sector_address_map u_map (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(cmd_addr_i),
        .sector_o(sector_o),
        .small_block_o(small_block_o),
        .large_block_o(large_block_o),
        .sector_base_o(sector_base_o),
        .sector_end_o(sector_end_o)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    // the finishing cycle is left out: busy legally drops right after it
    busy_readonly_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_status_wr && state_q == ST_BUSY && !op_done
        |=> write_in_progress_flag_q)
        else $error("busy flag disturbed by status write");
    busy_start_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_prog && start_ok |=> write_in_progress_flag_q)
        else $error("accepted program did not set busy");
    busy_end_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        op_done |=> !write_in_progress_flag_q && !write_enable_latch_q)
        else $error("completion did not clear busy and latch");
    // a restart would reload the busy counter instead of counting down
    no_start_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == ST_BUSY && is_modify
        |=> busy_cnt_q == $past(busy_cnt_q) - 16'h0001)
        else $error("operation started while busy");
    chip_guard_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_chip && block_protect_q != 4'h0 |=> cmd_ignored_o)
        else $error("chip erase not ignored while protected");
    lock_guard_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_status_wr && locked |=> cmd_ignored_o)
        else $error("locked status write accepted");
    nv_stable_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !(op_done && op_q == OP_STATUS) |=> $stable(block_protect_q))
        else $error("protect bits changed outside status write");
    read_back_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cmd_valid_i && cmd_code_i == `CMD_READ_STATUS
        |=> read_valid_o && read_data_o == $past(status_byte))
        else $error("status read mismatch");
    busy_len_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(write_in_progress_flag_q) |-> write_in_progress_flag_q[*8])
        else $error("busy dropped too early");
endmodule : flash_status_regs
`default_nettype wire

/* tb/status_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_params.svh"

// ****************************************************************
// host side of the command port
// ****************************************************************
module status_host_model (
    input wire logic sys_clk_i,
    input wire logic busy_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_data_o,
    output logic [20:0] cmd_addr_o
);
    // quiet port from time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_data_o = 8'h00;
        cmd_addr_o = 21'h000000;
    end

    // one-cycle command; the fields then show the inverse, so a stale
    // value can never pass for a fresh one
    task automatic issue(input logic [7:0] c, input logic [7:0] d,
                         input logic [20:0] a);
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= c;
        cmd_data_o <= d;
        cmd_addr_o <= a;
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~c;
        cmd_data_o <= ~d;
        cmd_addr_o <= ~a;
    endtask : issue

    // write enable goes ahead of every modifying command
    task automatic modify(input logic [7:0] c, input logic [7:0] d,
                          input logic [20:0] a);
        issue(`CMD_WRITE_ENABLE, 8'h00, a);
        issue(c, d, a);
    endtask : modify

    // bounded poll of the busy flag before the next modifying command
    task automatic wait_ready(output logic ok);
        int n = 0;
        while (n < 400 && busy_i !== 1'b0) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        ok = (busy_i === 1'b0);
    endtask : wait_ready
endmodule : status_host_model
`default_nettype wire

/* tb/flash_status_and_array_map_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_params.svh"

module flash_status_and_array_map_bench;
    logic sys_clk_i, rst_n_i, write_protect_n_i, cmd_valid, ok;
    logic read_valid_o, cmd_ignored_o, quad_enable_o, busy_o;
    logic [7:0] cmd_code, cmd_data, read_data_o, sr, d;
    logic [20:0] cmd_addr, sector_base_o, sector_end_o, a;
    logic [8:0] sector_o;
    logic [5:0] small_block_o;
    logic [4:0] large_block_o;
    logic [7:0] codes [6] = '{8'hc7, 8'h60, 8'h02, 8'h20, 8'h52, 8'hd8};
    int err_count = 0;
    int n_compared = 0;

    flash_status_regs DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
        .cmd_data_i(cmd_data), .cmd_addr_i(cmd_addr),
        .write_protect_n_i(write_protect_n_i), .read_data_o(read_data_o),
        .read_valid_o(read_valid_o), .cmd_ignored_o(cmd_ignored_o),
        .quad_enable_o(quad_enable_o), .busy_o(busy_o),
        .sector_o(sector_o), .small_block_o(small_block_o),
        .large_block_o(large_block_o), .sector_base_o(sector_base_o),
        .sector_end_o(sector_end_o));
    status_host_model host (.sys_clk_i(sys_clk_i), .busy_i(busy_o),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
        .cmd_data_o(cmd_data), .cmd_addr_o(cmd_addr));

    // 20 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // status read; the address rides along to check the array map
    task automatic rd(input logic [7:0] e, input logic [20:0] ad);
        host.issue(`CMD_READ_STATUS, 8'h00, ad);
        #1;
        check("read_valid", 1, read_valid_o);
        check("status", e, read_data_o);
        check("sector", ad[20:12], sector_o);
        check("small", ad[20:15], small_block_o);
        check("large", ad[20:16], large_block_o);
        check("base", {ad[20:12], 12'h000}, sector_base_o);
        check("end", {ad[20:12], 12'hfff}, sector_end_o);
    endtask : rd

    // modifying command, refused or run to completion
    task automatic modop(input logic [7:0] c, input logic [7:0] dt,
                         input logic acc);
        host.modify(c, dt, a);
        #1;
        check("ignored", !acc, cmd_ignored_o);
        if (acc) begin
            @(posedge sys_clk_i);
            #1;
            check("busy", 1, busy_o);
            wait_done();
        end else begin
            host.issue(`CMD_WRITE_DISABLE, 8'h00, a);
        end
    endtask : modop

    task automatic wait_done;
        host.wait_ready(ok);
        if (!ok) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_done

    initial begin
        void'($urandom(32'h921aeb1f));
        rst_n_i = 1'b0;
        write_protect_n_i = 1'b1;
        a = 21'h000000;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("busy_rst", 0, busy_o);
        check("quad_rst", 0, quad_enable_o);
        rd(8'h00, 21'h000000);
        $display("test reset values done");
        host.issue(`CMD_WRITE_STATUS, 8'hfc, 21'h1fffff);
        #1;
        check("no_enable", 1, cmd_ignored_o);
        host.issue(`CMD_WRITE_ENABLE, 8'h00, 21'h000fff);
        rd(8'h02, 21'h000fff);
        host.issue(`CMD_WRITE_DISABLE, 8'h00, 21'h001000);
        rd(8'h00, 21'h001000);
        $display("test latch done");
        sr = 8'h00;
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            a = 21'($urandom);
            host.modify(`CMD_WRITE_STATUS, d, a);
            rd({sr[7:2], 2'b11}, a);
            host.issue(`CMD_WRITE_STATUS, ~d, a);
            #1;
            check("busy_refuse", 1, cmd_ignored_o);
            wait_done();
            sr = {d[7:2], 2'b00};
            rd(sr, a);
            check("quad", sr[6], quad_enable_o);
        end
        $display("test random status writes done");
        modop(`CMD_WRITE_STATUS, 8'h84, 1'b1);
        @(posedge sys_clk_i);
        write_protect_n_i <= 1'b0;
        modop(`CMD_WRITE_STATUS, 8'h00, 1'b0);
        rd(8'h84, a);
        @(posedge sys_clk_i);
        write_protect_n_i <= 1'b1;
        modop(`CMD_CHIP_ERASE, 8'h00, 1'b0);
        modop(`CMD_WRITE_STATUS, 8'h00, 1'b1);
        $display("test lock and protect done");
        foreach (codes[k]) begin
            a = 21'($urandom);
            modop(codes[k], 8'h00, 1'b1);
            rd(8'h00, a);
        end
        $display("test program and erase done");
        report_and_stop();
    end
endmodule : flash_status_and_array_map_bench
`default_nettype wire
